// ### include/wdg_pkg.sv
/*
 Package for the watchdog block: register offsets, field positions,
 reset values, timing constants and the state type.
 Assumes a single 200 MHz clock domain with a plain register port.
*/
`default_nettype none
package wdg_pkg;
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned LOW_POWER_RC_CLOCK_HZ = 32000;
	// Core clock cycles per slow watchdog tick, derived from the core clock
	localparam int unsigned LOW_POWER_RC_CLOCK_DIV = (CLK_HZ + LOW_POWER_RC_CLOCK_HZ - 1) / LOW_POWER_RC_CLOCK_HZ;
	localparam int unsigned PRE_SHORT = 32;
	localparam int unsigned PRE_LONG = 128;
	localparam int unsigned POST_MAX_LOG2 = 15;
	localparam int unsigned LOW_POWER_RC_CLOCK_DIV_W = 13;
	localparam int unsigned PRE_W = 7;
	localparam int unsigned POST_W = 15;

	localparam logic [3:0] ADDR_RESET_CONTROL_REG = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_MASK = 4'h2;
	localparam logic [3:0] ADDR_COUNT = 4'h3;

	localparam int unsigned BIT_SW_ENABLE = 5;
	localparam int unsigned BIT_TIMEOUT = 4;
	localparam int unsigned BIT_SLEEP = 3;
	localparam int unsigned BIT_IDLE = 2;

	localparam int unsigned CFG_BIT_HW_ENABLE = 7;
	localparam int unsigned CFG_BIT_WINDOW_DIS = 6;
	localparam int unsigned CFG_BIT_PRESCALE = 4;
	localparam int unsigned CFG_POST_LSB = 0;

	localparam int unsigned EV_TIMEOUT_RESET = 0;
	localparam int unsigned EV_TIMEOUT_WAKE = 1;
	localparam int unsigned EV_EARLY_KICK = 2;
	localparam int unsigned EV_W = 3;

	localparam logic [15:0] RESET_CONTROL_REG_RESET = 16'h0000;
	localparam logic [EV_W-1:0] STATUS_RESET = 3'h0;
	localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

	typedef enum logic [2:0] {
		WDG_RUN = 3'b001,
		WDG_SAVE = 3'b010,
		WDG_FIRE = 3'b100
	} wdg_state_type;
endpackage
`default_nettype wire

// ### include/wdg_tick_if.sv
/*
 Interface carrying the counter restart, run and scale selects, and the time-out,
 window and post count back, between the watchdog top and its divider chain.
 Assumes both ends share mclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface wdg_tick_if;
	logic restart;
	logic run;
	logic prescale_long;
	logic [3:0] postscale_select;
	logic timeout;
	logic in_window;
	logic [14:0] post_count;
	modport ctrl (output restart, output run, output prescale_long,
		output postscale_select, input timeout, input in_window, input post_count);
	modport chain (input restart, input run, input prescale_long,
		input postscale_select, output timeout, output in_window, output post_count);
endinterface
`default_nettype wire

// ### rtl/wdg_sync.sv
/*
 Two-flip-flop synchroniser for a group of level inputs.
 Assumes inputs are quasi-static levels from outside the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module wdg_sync #(
	parameter int unsigned W = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule // wdg_sync
`default_nettype wire

// ### rtl/wdg_chain.sv
/*
 Low-power RC tick divider, prescaler and postscaler of the watchdog.
 Assumes the controller pulses restart for a clear, reset, clock switch
 or power-save transition.
*/
`timescale 1ns/1ps
`default_nettype none
module wdg_chain
	import wdg_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	wdg_tick_if.chain tick
);
	logic [LOW_POWER_RC_CLOCK_DIV_W-1:0] rc_reg, rc_next;
	logic [PRE_W-1:0] pre_reg, pre_next;
	logic [POST_W-1:0] post_reg, post_next;
	logic rc_tick, pre_tick;
	logic [PRE_W-1:0] pre_last;
	logic [POST_W-1:0] post_last;

	always_comb begin
		pre_last = tick.prescale_long ? PRE_W'(PRE_LONG - 1) : PRE_W'(PRE_SHORT - 1);
		post_last = POST_W'((32'h1 << tick.postscale_select) - 1);
		rc_tick = (rc_reg == LOW_POWER_RC_CLOCK_DIV_W'(LOW_POWER_RC_CLOCK_DIV - 1));
		pre_tick = rc_tick && (pre_reg == pre_last);
		rc_next = rc_reg;
		pre_next = pre_reg;
		post_next = post_reg;
		if (tick.restart || !tick.run) begin // see RQ10
			rc_next = '0;
			pre_next = '0;
			post_next = '0;
		end else begin
			rc_next = rc_tick ? '0 : rc_reg + 1'b1; // see RQ8
			if (rc_tick)
				pre_next = pre_tick ? '0 : pre_reg + 1'b1; // see RQ8
			if (pre_tick)
				post_next = (post_reg == post_last) ? '0 : post_reg + 1'b1; // see RQ9
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rc_reg <= '0;
			pre_reg <= '0;
			post_reg <= '0;
		end else begin
			rc_reg <= rc_next;
			pre_reg <= pre_next;
			post_reg <= post_next;
		end
	end

	assign tick.timeout = tick.run && !tick.restart && pre_tick && (post_reg == post_last); // see RQ9
	// Last quarter of the period, in prescaler ticks; short periods fall back to prescaler, so select 1 opens only the last eighth
	always_comb begin
		if (tick.postscale_select >= 4'h2)
			tick.in_window = (post_reg >= (post_last - (post_last >> 2)));
		else
			tick.in_window = (post_reg == post_last) && (pre_reg >= (pre_last - (pre_last >> 2)));
	end
	assign tick.post_count = post_reg;
endmodule // wdg_chain
`default_nettype wire

// ### rtl/wdg_top.sv
/*
 Watchdog enable, windowed clear and time-out flag logic, with a small
 register port and one interrupt output.
 Assumes configuration word bits are static after reset and that the
 core pulses the instruction inputs for one mclk cycle each.
*/
// Contract
// RQ1: Hardware enable fuse set keeps the watchdog always running, software bit ignored.
// RQ2: Fuse clear: watchdog runs only while software enable bit 5 is set.
// RQ3: Any device reset clears the software enable bit.
// RQ4: Window mode: software clears only in the last quarter of the period. At postscale select 1 the code opens only the last eighth.
// RQ5: Window mode: a clear before the window opens causes a watchdog reset.
// RQ6: Time-out flag bit 4 stays set until software clears it.
// RQ7: Time-out flag sets in the same cycle as the time-out reset or wake.
// RQ8: Prescaler divides the RC tick by 32 or 128 per prescale select.
// RQ9: Postscaler divides further by one of 16 ratios, 1:1 to 1:32768.
// RQ10: Counters restart on reset, clock switch, power-save entry/exit, clear.
// RQ11: Counting continues in Sleep and Idle; time-out there wakes instead of resetting.
`timescale 1ns/1ps
`default_nettype none
module wdg_top (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] watchdog_config_word,
	input wire logic kick_instruction,
	input wire logic power_save_instruction,
	input wire logic power_save_idle,
	input wire logic power_save_exit,
	input wire logic clock_switch_done,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	output logic watchdog_reset,
	output logic watchdog_wake,
	output logic irq
);
	import wdg_pkg::*;

	logic rst_meta_reg, rst_sync_reg;
	logic rst_n;
	logic [7:0] cfg_sync;
	logic hw_enable_fuse;
	logic window_disable_bit;
	logic sw_enable_bit_reg, sw_enable_bit_next;
	logic timeout_flag_reg, timeout_flag_next;
	logic sleep_flag_reg, sleep_flag_next;
	logic idle_flag_reg, idle_flag_next;
	logic [EV_W-1:0] status_reg, status_next;
	logic [EV_W-1:0] mask_reg, mask_next;
	logic [15:0] rdata_reg, rdata_next;
	logic reset_out_reg, reset_out_next;
	logic wake_out_reg, wake_out_next;
	wdg_state_type state_reg, state_next;
	logic running;
	logic early_kick;
	logic fire_reset, fire_wake;
	logic [EV_W-1:0] events;
	logic wr_reset_control_reg, wr_status, wr_mask;

	wdg_tick_if tick ();

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	wdg_sync #(.W(8)) u_cfg_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in(watchdog_config_word),
		.sync_out(cfg_sync)
	);

	wdg_chain u_chain (
		.mclk(mclk),
		.rst_n(rst_n),
		.tick(tick)
	);

	assign hw_enable_fuse = cfg_sync[CFG_BIT_HW_ENABLE];
	assign window_disable_bit = cfg_sync[CFG_BIT_WINDOW_DIS];
	assign running = hw_enable_fuse || sw_enable_bit_reg; // see RQ1 see RQ2

	assign tick.run = running;
	assign tick.prescale_long = cfg_sync[CFG_BIT_PRESCALE]; // see RQ8
	assign tick.postscale_select = cfg_sync[CFG_POST_LSB +: 4]; // see RQ9
	// see RQ10
	assign tick.restart = kick_instruction || power_save_instruction
		|| power_save_exit || clock_switch_done || (state_reg == WDG_FIRE);

	// Software that clears too early is punished; the host keeps to the window
	assign early_kick = running && kick_instruction && !window_disable_bit
		&& (state_reg == WDG_RUN) && !tick.in_window; // see RQ4 see RQ5

	assign fire_reset = (tick.timeout && (state_reg == WDG_RUN)) || early_kick; // see RQ5
	assign fire_wake = tick.timeout && (state_reg == WDG_SAVE); // see RQ11

	// Register port decode, shared by the three writable registers
	function automatic logic reg_hit(input logic strobe, input logic [3:0] addr,
		input logic [3:0] offset);
		return strobe && (addr == offset);
	endfunction

	assign wr_reset_control_reg = reg_hit(reg_write, reg_addr, ADDR_RESET_CONTROL_REG);
	assign wr_status = reg_hit(reg_write, reg_addr, ADDR_STATUS);
	assign wr_mask = reg_hit(reg_write, reg_addr, ADDR_MASK);

	always_comb begin
		events = '0;
		events[EV_TIMEOUT_RESET] = tick.timeout && (state_reg == WDG_RUN);
		events[EV_TIMEOUT_WAKE] = fire_wake;
		events[EV_EARLY_KICK] = early_kick;
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			WDG_RUN: begin
				if (fire_reset)
					state_next = WDG_FIRE;
				else if (power_save_instruction)
					state_next = WDG_SAVE;
			end
			WDG_SAVE: begin
				// Keeps counting while asleep or idle
				if (fire_wake || power_save_exit) // see RQ11
					state_next = WDG_RUN;
			end
			// One-cycle reset pulse, then device logic comes back up
			WDG_FIRE: state_next = WDG_RUN;
			default: state_next = WDG_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= WDG_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	always_comb begin
		sw_enable_bit_next = sw_enable_bit_reg;
		timeout_flag_next = timeout_flag_reg;
		sleep_flag_next = sleep_flag_reg;
		idle_flag_next = idle_flag_reg;
		if (wr_reset_control_reg) begin
			sw_enable_bit_next = reg_wdata[BIT_SW_ENABLE]; // see RQ2
			timeout_flag_next = reg_wdata[BIT_TIMEOUT]; // see RQ6
			sleep_flag_next = reg_wdata[BIT_SLEEP];
			idle_flag_next = reg_wdata[BIT_IDLE];
		end
		if (power_save_instruction && (state_reg == WDG_RUN)) begin
			sleep_flag_next = !power_save_idle;
			idle_flag_next = power_save_idle;
		end
		// The watchdog reset is a device reset: software enable drops
		if (fire_reset)
			sw_enable_bit_next = 1'b0; // see RQ3
		// Set wins over a software clear in the same cycle
		if (fire_reset || fire_wake)
			timeout_flag_next = 1'b1; // see RQ6 see RQ7
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sw_enable_bit_reg <= RESET_CONTROL_REG_RESET[BIT_SW_ENABLE]; // see RQ3
			timeout_flag_reg <= RESET_CONTROL_REG_RESET[BIT_TIMEOUT];
			sleep_flag_reg <= RESET_CONTROL_REG_RESET[BIT_SLEEP];
			idle_flag_reg <= RESET_CONTROL_REG_RESET[BIT_IDLE];
		end else begin
			sw_enable_bit_reg <= sw_enable_bit_next;
			timeout_flag_reg <= timeout_flag_next;
			sleep_flag_reg <= sleep_flag_next;
			idle_flag_reg <= idle_flag_next;
		end
	end

	// Write-one-to-clear; an event in the same cycle keeps its bit set
	always_comb begin
		status_next = status_reg;
		mask_next = mask_reg;
		if (wr_status)
			status_next = status_reg & ~reg_wdata[EV_W-1:0];
		status_next = status_next | events;
		if (wr_mask)
			mask_next = reg_wdata[EV_W-1:0];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= STATUS_RESET;
			mask_reg <= MASK_RESET;
		end else begin
			status_reg <= status_next;
			mask_reg <= mask_next;
		end
	end

	always_comb begin
		rdata_next = 16'h0000;
		if (reg_read) begin
			case (reg_addr)
				ADDR_RESET_CONTROL_REG: begin
					rdata_next[BIT_SW_ENABLE] = sw_enable_bit_reg;
					rdata_next[BIT_TIMEOUT] = timeout_flag_reg;
					rdata_next[BIT_SLEEP] = sleep_flag_reg;
					rdata_next[BIT_IDLE] = idle_flag_reg;
				end
				ADDR_STATUS: rdata_next[EV_W-1:0] = status_reg;
				ADDR_MASK: rdata_next[EV_W-1:0] = mask_reg;
				ADDR_COUNT: rdata_next[POST_W-1:0] = tick.post_count;
				default: rdata_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Output pulses are registered so the core sees a clean one-cycle level
	always_comb begin
		reset_out_next = fire_reset; // see RQ7
		wake_out_next = fire_wake; // see RQ11
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reset_out_reg <= 1'b0;
			wake_out_reg <= 1'b0;
		end else begin
			reset_out_reg <= reset_out_next;
			wake_out_reg <= wake_out_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign watchdog_reset = reset_out_reg;
	assign watchdog_wake = wake_out_reg;
	assign irq = |(status_reg & mask_reg);
endmodule // wdg_top
`default_nettype wire

// ### test/wdg_top_properties.sv
/*
 Checker for the watchdog top: register port timing, reset and wake
 pulses, interrupt level.
 Assumes it is bound to wdg_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module wdg_top_properties
	import wdg_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] watchdog_config_word,
	input wire logic kick_instruction,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic watchdog_reset,
	input wire logic watchdog_wake,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("read data outside its slot");
	unmapped_read_a: assert property (reg_read && reg_addr > ADDR_COUNT |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	reset_single_a: assert property (watchdog_reset |=> !watchdog_reset)
		else $error("reset pulse too long");
	wake_single_a: assert property (watchdog_wake |=> !watchdog_wake)
		else $error("wake pulse too long");
	reset_wake_excl_a: assert property (!(watchdog_reset && watchdog_wake))
		else $error("reset and wake together");
	quiet_start_a: assert property ($rose(resetn) |-> !watchdog_reset && !irq ##1 !watchdog_reset && !irq)
		else $error("output active right after reset");
	window_off_a: assert property (kick_instruction && watchdog_config_word[6] |=> !watchdog_reset)
		else $error("kick fired reset with window off");
	status_clear_a: assert property (reg_write && reg_addr == ADDR_STATUS && reg_wdata[2:0] == 3'h7
		|=> !irq || watchdog_reset || watchdog_wake)
		else $error("irq stays after status clear");
	mask_zero_a: assert property (reg_write && reg_addr == ADDR_MASK && reg_wdata[2:0] == 3'h0 |=> !irq)
		else $error("irq with mask zero");
endmodule // wdg_top_properties
bind wdg_top wdg_top_properties u_props (.mclk, .resetn, .watchdog_config_word, .kick_instruction,
	.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .watchdog_reset, .watchdog_wake, .irq);
`default_nettype wire

// ### test/tb_watchdog_enable_window_control.sv
/*
 Testbench for the watchdog top: enable paths, windowed kick, flags, irq.
 Assumes wdg_top with its checker bound; a full time-out is far beyond
 the run length, so early clears, power-save and flags are exercised.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_enable_window_control;
	import wdg_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] cfg = 8'h00;
	logic kick = 1'b0;
	logic ps_enter = 1'b0;
	logic ps_idle = 1'b0;
	logic ps_exit = 1'b0;
	logic clk_sw = 1'b0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic wd_rst;
	logic wake;
	logic irq;
	int bad_count = 0;
	int n_checks = 0;
	always #2.5 mclk = ~mclk;
	wdg_top DUT (.mclk(mclk), .resetn(resetn), .watchdog_config_word(cfg),
		.kick_instruction(kick), .power_save_instruction(ps_enter), .power_save_idle(ps_idle),
		.power_save_exit(ps_exit), .clock_switch_done(clk_sw), .reg_addr(addr),
		.reg_wdata(wdata), .reg_write(we), .reg_read(re), .reg_rdata(rdata),
		.watchdog_reset(wd_rst), .watchdog_wake(wake), .irq(irq));
	task automatic print_verdict();
		if (bad_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge mclk);
		we <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m = 16'hffff);
		@(posedge mclk);
		addr <= a;
		re <= 1'b1;
		@(posedge mclk);
		re <= 1'b0;
		#1;
		check("rdata", rdata & m, exp);
	endtask
	// Counts any reset pulse over the few cycles after the kick is taken
	task automatic kick_exp(input logic e);
		logic seen;
		logic seen_wake;
		seen = 1'b0;
		seen_wake = 1'b0;
		@(posedge mclk);
		kick <= 1'b1;
		@(posedge mclk);
		kick <= 1'b0;
		repeat (4) begin
			#1 seen = seen | wd_rst;
			seen_wake = seen_wake | wake;
			@(posedge mclk);
		end
		check("watchdog_reset", {15'h0000, seen}, {15'h0000, e});
		check("watchdog_wake", {15'h0000, seen_wake}, 16'h0000);
	endtask
	// Power-save entry, exit and clock-switch pulses, one cycle each
	task automatic ps(input logic enter, input logic idle_sel, input logic leave, input logic sw);
		@(posedge mclk);
		ps_enter <= enter;
		ps_idle <= idle_sel;
		ps_exit <= leave;
		clk_sw <= sw;
		@(posedge mclk);
		ps_enter <= 1'b0;
		ps_exit <= 1'b0;
		clk_sw <= 1'b0;
	endtask
	// Config is static, so it only changes while reset is held
	task automatic boot(input logic [7:0] c);
		@(posedge mclk);
		resetn <= 1'b0;
		cfg <= c;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		repeat (6) @(posedge mclk);
	endtask
	initial begin
		boot(8'h00);
		for (int a = 0; a < 6; a++) begin
			rd(a[3:0], 16'h0000);
		end
		kick_exp(1'b0);
		wr(ADDR_RESET_CONTROL_REG, 16'h0020);
		rd(ADDR_RESET_CONTROL_REG, 16'h0020);
		kick_exp(1'b1);
		rd(ADDR_RESET_CONTROL_REG, 16'h0000, 16'h0020);
		rd(ADDR_STATUS, 16'h0004);
		check("irq", {15'h0000, irq}, 16'h0000);
		wr(ADDR_MASK, 16'h0004);
		check("irq", {15'h0000, irq}, 16'h0001);
		wr(ADDR_STATUS, 16'h0007);
		check("irq", {15'h0000, irq}, 16'h0000);
		rd(ADDR_STATUS, 16'h0000);
		boot(8'h40);
		rd(ADDR_MASK, 16'h0000);
		wr(ADDR_RESET_CONTROL_REG, 16'h0030);
		kick_exp(1'b0);
		rd(ADDR_RESET_CONTROL_REG, 16'h0030);
		wr(ADDR_MASK, 16'h0000);
		wr(ADDR_RESET_CONTROL_REG, 16'h0000);
		rd(ADDR_RESET_CONTROL_REG, 16'h0000);
		boot(8'h80);
		kick_exp(1'b1);
		kick_exp(1'b1);
		rd(ADDR_RESET_CONTROL_REG, 16'h0000, 16'h0020);
		ps(1'b1, 1'b0, 1'b0, 1'b0);
		rd(ADDR_RESET_CONTROL_REG, 16'h0008, 16'h000c);
		kick_exp(1'b0);
		ps(1'b0, 1'b0, 1'b1, 1'b1);
		kick_exp(1'b1);
		ps(1'b1, 1'b1, 1'b0, 1'b0);
		rd(ADDR_RESET_CONTROL_REG, 16'h0004, 16'h000c);
		ps(1'b0, 1'b0, 1'b1, 1'b0);
		print_verdict();
	end
	initial begin
		repeat (5000) @(posedge mclk);
		bad_count++;
		print_verdict();
	end
endmodule // tb_watchdog_enable_window_control
`default_nettype wire
